//--- common/current_scaler_pkg.sv
// Package with register map, field layouts and codes of the current selector and scaler.
// How it works
// - Raw samples are unsigned 16-bit values from zero to 65535.
// - Every raw source arrives 16 bits wide and is readable as such.
// - Scaler removes programmed offset and yields zero-centred signed 16-bit values.
// - Scaled outputs to the control engine are signed 16-bit.
// - Two selectors route one of four raw inputs onto channel zero or one.
// - Each channel computes (raw minus offset) times Q8.8 gain divided by 256.
// - Offset subtraction turns the unsigned sample into a signed value.
// - Three-phase mode derives third current as minus sum of scaled pair.
// - Two-phase stepper mode computes no third current; it reads zero.
// - Three output selectors pick scaled zero, scaled one or third current.
// - All three phase outputs serve three-phase; two-phase uses U/X and W/Y.
package current_scaler_pkg;

    // Byte offsets of the registers.
    localparam logic [7:0] REG_SOURCE_SEL   = 8'h00;
    localparam logic [7:0] REG_OFFSET_CH0   = 8'h04;
    localparam logic [7:0] REG_OFFSET_CH1   = 8'h08;
    localparam logic [7:0] REG_GAIN_CH0     = 8'h0C;
    localparam logic [7:0] REG_GAIN_CH1     = 8'h10;
    localparam logic [7:0] REG_ROUTE_SEL    = 8'h14;
    localparam logic [7:0] REG_MODE         = 8'h18;
    localparam logic [7:0] REG_RAW_INT      = 8'h1C;
    localparam logic [7:0] REG_RAW_EXT      = 8'h20;
    localparam logic [7:0] REG_RAW_ROUTED   = 8'h24;
    localparam logic [7:0] REG_SCALED       = 8'h28;
    localparam logic [7:0] REG_THIRD        = 8'h2C;
    localparam logic [7:0] REG_PHASE_UX_V   = 8'h30;
    localparam logic [7:0] REG_PHASE_WY     = 8'h34;

    // Field positions.
    localparam int SEL_CH0_LSB   = 0;
    localparam int SEL_CH1_LSB   = 8;
    localparam int ROUTE_UX_LSB  = 0;
    localparam int ROUTE_V_LSB   = 8;
    localparam int ROUTE_WY_LSB  = 16;
    localparam int HI_HALF_LSB   = 16;
    localparam int GAIN_SHIFT    = 8;

    // Source codes for the raw channel selectors.
    localparam logic [7:0] SRC_INT_U = 8'h00;
    localparam logic [7:0] SRC_INT_V = 8'h01;
    localparam logic [7:0] SRC_EXT_0 = 8'h02;
    localparam logic [7:0] SRC_EXT_1 = 8'h03;

    // Codes for the phase output selectors.
    localparam logic [7:0] ROUTE_CH0   = 8'h00;
    localparam logic [7:0] ROUTE_CH1   = 8'h01;
    localparam logic [7:0] ROUTE_THIRD = 8'h02;

    // Mode codes.
    localparam logic [1:0] MODE_SINGLE_COIL = 2'h0;
    localparam logic [1:0] MODE_TWO_PHASE   = 2'h1;
    localparam logic [1:0] MODE_THREE_PHASE = 2'h2;

    // Values after reset.
    localparam logic [31:0] RST_SOURCE_SEL = 32'h0000_0100;
    localparam logic [15:0] RST_OFFSET     = 16'h8000;
    localparam logic [15:0] RST_GAIN       = 16'h0100;
    localparam logic [31:0] RST_ROUTE_SEL  = 32'h0002_0100;
    localparam logic [1:0]  RST_MODE       = MODE_THREE_PHASE;

    // Signed 16-bit limits.
    localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
    localparam logic signed [15:0] S16_MIN = -16'sh8000;

    // Wishbone slave state.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage

//--- hw/current_channel_scaler.sv
// Offset removal, Q8.8 gain and saturation for one current channel.
`timescale 1ns/1ps
`default_nettype none
module current_channel_scaler
    import current_scaler_pkg::*;
(
    // Operands.
    input  wire logic        [15:0] raw_sample,
    input  wire logic        [15:0] offset_value,
    input  wire logic signed [15:0] gain_factor,
    // Result.
    output logic signed      [15:0] scaled_value
);

    logic signed [16:0] centred;
    logic signed [32:0] product;
    logic signed [32:0] shifted;

    // Zero extend both operands so the difference is a true signed value.
    assign centred = $signed({1'b0, raw_sample}) - $signed({1'b0, offset_value});
    // Multiply by the Q8.8 gain and drop the fractional byte.
    assign product = 33'(centred * gain_factor);
    assign shifted = product >>> GAIN_SHIFT;

    // Clamp to the signed 16-bit range instead of wrapping.
    always_comb
    begin
        if (shifted > 33'(S16_MAX))
            scaled_value = S16_MAX;
        else if (shifted < 33'(S16_MIN))
            scaled_value = S16_MIN;
        else
            scaled_value = shifted[15:0];
    end

endmodule // current_channel_scaler
`default_nettype wire

//--- hw/current_adc_select_scaler.sv
// Raw source selection, scaling, third current and phase routing with Wishbone registers.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module current_adc_select_scaler
    import current_scaler_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Raw samples from the decimation filters.
    input  wire logic [15:0] internal_sample_u,
    input  wire logic [15:0] internal_sample_v,
    input  wire logic [15:0] external_sample_zero,
    input  wire logic [15:0] external_sample_one,
    // Phase currents to the control engine.
    output logic signed [15:0] phase_ux_current,
    output logic signed [15:0] phase_v_current,
    output logic signed [15:0] phase_wy_current,
    // Mode flags to the control engine.
    output logic             three_phase_vector_mode,
    output logic             two_phase_stepper_mode,
    output logic             single_coil_dc_mode
);

    // All state of the block.
    typedef struct packed {
        bus_state_t         bus;
        logic        [31:0] rdata;
        logic        [7:0]  ch0_source_select;
        logic        [7:0]  ch1_source_select;
        logic        [15:0] ch0_offset_value;
        logic        [15:0] ch1_offset_value;
        logic        [15:0] ch0_gain_factor;
        logic        [15:0] ch1_gain_factor;
        logic        [7:0]  phase_ux_route_select;
        logic        [7:0]  phase_v_route_select;
        logic        [7:0]  phase_wy_route_select;
        logic        [1:0]  mode;
        logic        [15:0] routed_raw_ch0;
        logic        [15:0] routed_raw_ch1;
        logic        [15:0] scaled_current_ch0;
        logic        [15:0] scaled_current_ch1;
        logic        [15:0] derived_third_current;
        logic        [15:0] ux;
        logic        [15:0] v;
        logic        [15:0] wy;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic signed [15:0] scaled_ch0;
    logic signed [15:0] scaled_ch1;

    // Pick one raw source; unknown codes give zero.
    function automatic logic [15:0] pick_source(input logic [7:0] code,
                                                input logic [15:0] s_u,
                                                input logic [15:0] s_v,
                                                input logic [15:0] s_e0,
                                                input logic [15:0] s_e1);
        case (code)
            SRC_INT_U: pick_source = s_u;
            SRC_INT_V: pick_source = s_v;
            SRC_EXT_0: pick_source = s_e0;
            SRC_EXT_1: pick_source = s_e1;
            default:   pick_source = 16'h0000;
        endcase
    endfunction

    // Pick one scaled channel for a phase output; unknown codes give zero.
    function automatic logic [15:0] pick_route(input logic [7:0] code,
                                               input logic [15:0] c0,
                                               input logic [15:0] c1,
                                               input logic [15:0] c2);
        case (code)
            ROUTE_CH0:   pick_route = c0;
            ROUTE_CH1:   pick_route = c1;
            ROUTE_THIRD: pick_route = c2;
            default:     pick_route = 16'h0000;
        endcase
    endfunction

    // Merge write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[b*8 +: 8] = wdat[b*8 +: 8];
        end
        merge = res;
    endfunction

    // Limit an 18-bit value to the signed 16-bit range.
    function automatic logic [15:0] sat18(input logic signed [17:0] val);
        if (val > 18'(S16_MAX))
            sat18 = S16_MAX;
        else if (val < 18'(S16_MIN))
            sat18 = S16_MIN;
        else
            sat18 = val[15:0];
    endfunction

    // The two channel scalers work on the routed raw samples.
    current_channel_scaler u_scale_ch0 (
        .raw_sample   (state_r.routed_raw_ch0),
        .offset_value (state_r.ch0_offset_value),
        .gain_factor  ($signed(state_r.ch0_gain_factor)),
        .scaled_value (scaled_ch0)
    );

    current_channel_scaler u_scale_ch1 (
        .raw_sample   (state_r.routed_raw_ch1),
        .offset_value (state_r.ch1_offset_value),
        .gain_factor  ($signed(state_r.ch1_gain_factor)),
        .scaled_value (scaled_ch1)
    );

    // Next-state logic: datapath pipeline and register bus.
    always_comb
    begin
        logic [31:0]        cur;
        logic [31:0]        upd;
        logic signed [16:0] sum;
        cur = 32'h0000_0000;
        upd = 32'h0000_0000;
        sum = 17'sh00000;
        state_nxt = state_r;

        // Stage one routes raw samples, already 16 bits wide, onto the channels.
        state_nxt.routed_raw_ch0 = pick_source(state_r.ch0_source_select, internal_sample_u,
            internal_sample_v, external_sample_zero, external_sample_one);
        state_nxt.routed_raw_ch1 = pick_source(state_r.ch1_source_select, internal_sample_u,
            internal_sample_v, external_sample_zero, external_sample_one);

        // Stage two registers the scaled pair.
        state_nxt.scaled_current_ch0 = scaled_ch0;
        state_nxt.scaled_current_ch1 = scaled_ch1;

        // Stage three forms the third current only in three-phase mode.
        sum = $signed({state_r.scaled_current_ch0[15], state_r.scaled_current_ch0})
            + $signed({state_r.scaled_current_ch1[15], state_r.scaled_current_ch1});
        if (state_r.mode == MODE_THREE_PHASE)
            state_nxt.derived_third_current = sat18(-18'(sum));
        else
            state_nxt.derived_third_current = 16'h0000;

        // Stage three also routes the scaled channels to the phase outputs.
        state_nxt.ux = pick_route(state_r.phase_ux_route_select, state_r.scaled_current_ch0,
            state_r.scaled_current_ch1, state_r.derived_third_current);
        state_nxt.v  = pick_route(state_r.phase_v_route_select, state_r.scaled_current_ch0,
            state_r.scaled_current_ch1, state_r.derived_third_current);
        state_nxt.wy = pick_route(state_r.phase_wy_route_select, state_r.scaled_current_ch0,
            state_r.scaled_current_ch1, state_r.derived_third_current);

        // Register bus: answer one cycle after the request, then drop ack.
        case (state_r.bus)
            BUS_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    case (wb_adr_i)
                        REG_SOURCE_SEL: cur = {16'h0000, state_r.ch1_source_select,
                                               state_r.ch0_source_select};
                        REG_OFFSET_CH0: cur = {16'h0000, state_r.ch0_offset_value};
                        REG_OFFSET_CH1: cur = {16'h0000, state_r.ch1_offset_value};
                        REG_GAIN_CH0:   cur = {16'h0000, state_r.ch0_gain_factor};
                        REG_GAIN_CH1:   cur = {16'h0000, state_r.ch1_gain_factor};
                        REG_ROUTE_SEL:  cur = {8'h00, state_r.phase_wy_route_select,
                                               state_r.phase_v_route_select,
                                               state_r.phase_ux_route_select};
                        REG_MODE:       cur = {30'h0000_0000, state_r.mode};
                        REG_RAW_INT:    cur = {internal_sample_v, internal_sample_u};
                        REG_RAW_EXT:    cur = {external_sample_one, external_sample_zero};
                        REG_RAW_ROUTED: cur = {state_r.routed_raw_ch1, state_r.routed_raw_ch0};
                        REG_SCALED:     cur = {state_r.scaled_current_ch1,
                                               state_r.scaled_current_ch0};
                        REG_THIRD:      cur = {16'h0000, state_r.derived_third_current};
                        REG_PHASE_UX_V: cur = {state_r.v, state_r.ux};
                        REG_PHASE_WY:   cur = {16'h0000, state_r.wy};
                        default:        cur = 32'h0000_0000;
                    endcase
                    state_nxt.rdata = cur;
                    state_nxt.bus   = BUS_ACK;
                    if (wb_we_i)
                    begin
                        upd = merge(cur, wb_dat_i, wb_sel_i);
                        case (wb_adr_i)
                            REG_SOURCE_SEL:
                            begin
                                state_nxt.ch0_source_select = upd[SEL_CH0_LSB +: 8];
                                state_nxt.ch1_source_select = upd[SEL_CH1_LSB +: 8];
                            end
                            REG_OFFSET_CH0: state_nxt.ch0_offset_value = upd[15:0];
                            REG_OFFSET_CH1: state_nxt.ch1_offset_value = upd[15:0];
                            REG_GAIN_CH0:   state_nxt.ch0_gain_factor  = upd[15:0];
                            REG_GAIN_CH1:   state_nxt.ch1_gain_factor  = upd[15:0];
                            REG_ROUTE_SEL:
                            begin
                                state_nxt.phase_ux_route_select = upd[ROUTE_UX_LSB +: 8];
                                state_nxt.phase_v_route_select  = upd[ROUTE_V_LSB +: 8];
                                state_nxt.phase_wy_route_select = upd[ROUTE_WY_LSB +: 8];
                            end
                            REG_MODE:       state_nxt.mode = upd[1:0];
                            default:        state_nxt.mode = state_r.mode;
                        endcase
                    end
                end
            end
            BUS_ACK:
            begin
                state_nxt.bus = BUS_IDLE;
            end
            default:
            begin
                state_nxt.bus = BUS_IDLE;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r                       <= '0;
            state_r.bus                   <= BUS_IDLE;
            state_r.ch0_source_select     <= RST_SOURCE_SEL[SEL_CH0_LSB +: 8];
            state_r.ch1_source_select     <= RST_SOURCE_SEL[SEL_CH1_LSB +: 8];
            state_r.ch0_offset_value      <= RST_OFFSET;
            state_r.ch1_offset_value      <= RST_OFFSET;
            state_r.ch0_gain_factor       <= RST_GAIN;
            state_r.ch1_gain_factor       <= RST_GAIN;
            state_r.phase_ux_route_select <= RST_ROUTE_SEL[ROUTE_UX_LSB +: 8];
            state_r.phase_v_route_select  <= RST_ROUTE_SEL[ROUTE_V_LSB +: 8];
            state_r.phase_wy_route_select <= RST_ROUTE_SEL[ROUTE_WY_LSB +: 8];
            state_r.mode                  <= RST_MODE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign wb_ack_o                = (state_r.bus == BUS_ACK);
    assign wb_dat_o                = state_r.rdata;
    assign phase_ux_current        = state_r.ux;
    assign phase_v_current         = state_r.v;
    assign phase_wy_current        = state_r.wy;
    assign three_phase_vector_mode = (state_r.mode == MODE_THREE_PHASE);
    assign two_phase_stepper_mode  = (state_r.mode == MODE_TWO_PHASE);
    assign single_coil_dc_mode     = (state_r.mode == MODE_SINGLE_COIL);

endmodule // current_adc_select_scaler
`default_nettype wire

//--- bench/current_scaler_chk.sv
// Checker of bus timing, mode flags and the default datapath of the scaler.
`timescale 1ns/1ps
`default_nettype none
module current_scaler_chk
    import current_scaler_pkg::*;
(
    // Clock, reset and bus.
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    // Samples and results.
    input wire logic [15:0]        internal_sample_u,
    input wire logic [15:0]        internal_sample_v,
    input wire logic signed [15:0] phase_ux_current,
    input wire logic signed [15:0] phase_v_current,
    input wire logic signed [15:0] phase_wy_current,
    input wire logic               three_phase_vector_mode,
    input wire logic               two_phase_stepper_mode,
    input wire logic               single_coil_dc_mode
);
    typedef struct packed {logic [2:0] settle; logic cfg_def;} chk_state_t;
    chk_state_t st_r;
    chk_state_t st_nxt;
    logic [2:0] flags;

    // Minus the sum of two offset-free samples, clamped to the signed range.
    function automatic logic [15:0] neg_sat(input logic [15:0] a, input logic [15:0] b);
        int s;
        s = 65536 - int'(a) - int'(b);
        if (s > 32767)
            return 16'h7FFF;
        if (s < -32768)
            return 16'h8000;
        return s[15:0];
    endfunction

    // The default datapath is only trusted once the pipeline has filled and before any write.
    assign flags = {three_phase_vector_mode, two_phase_stepper_mode, single_coil_dc_mode};
    always_comb
    begin
        st_nxt = st_r;
        if (st_r.settle != 3'h7)
            st_nxt.settle = st_r.settle + 3'h1;
        if (wb_ack_o && wb_we_i)
            st_nxt.cfg_def = 1'h0;
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st_r <= '{settle: 3'h0, cfg_def: 1'h1};
        else
            st_r <= st_nxt;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_ACK_ONE_CYCLE: assert property (s_take |=> s_ack_pulse)
        else $error("bus answer missing or longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("answer without request");
    AST_UNMAPPED_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i > REG_PHASE_WY |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_MODE_ONEHOT: assert property ($onehot0(flags))
        else $error("more than one mode flag");
    AST_MODE_WRITE: assert property ($changed(flags) |-> wb_ack_o && wb_we_i && wb_adr_i == REG_MODE)
        else $error("mode flags changed without mode write");
    AST_UX_DEFAULT: assert property (st_r.cfg_def && st_r.settle == 3'h7 |-> phase_ux_current == ($past(internal_sample_u, 3) ^ 16'h8000))
        else $error("default ux current wrong");
    AST_V_DEFAULT: assert property (st_r.cfg_def && st_r.settle == 3'h7 |-> phase_v_current == ($past(internal_sample_v, 3) ^ 16'h8000))
        else $error("default v current wrong");
    AST_WY_DEFAULT: assert property (st_r.cfg_def && st_r.settle == 3'h7 |-> phase_wy_current == neg_sat($past(internal_sample_u, 4), $past(internal_sample_v, 4)))
        else $error("default third current wrong");
endmodule // current_scaler_chk

bind current_adc_select_scaler current_scaler_chk chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .internal_sample_u(internal_sample_u), .internal_sample_v(internal_sample_v),
    .phase_ux_current(phase_ux_current), .phase_v_current(phase_v_current),
    .phase_wy_current(phase_wy_current), .three_phase_vector_mode(three_phase_vector_mode),
    .two_phase_stepper_mode(two_phase_stepper_mode), .single_coil_dc_mode(single_coil_dc_mode)
);
`default_nettype wire

//--- bench/sample_source_model.sv
// Model of the decimation filters that hand raw samples to the scaler.
`timescale 1ns/1ps
`default_nettype none
module sample_source_model (
    // Clock and control.
    input wire logic              core_clk,
    input wire logic              ramp_en,
    input wire logic [3:0][15:0]  set_val,
    // Raw samples.
    output logic      [15:0]      internal_sample_u,
    output logic      [15:0]      internal_sample_v,
    output logic      [15:0]      external_sample_zero,
    output logic      [15:0]      external_sample_one
);
    logic [3:0][15:0] smp_r;
    logic [3:0][15:0] smp_nxt;
    // Holds the set values, or ramps each source with wrap over the whole unsigned range.
    always_comb
    begin
        smp_nxt = set_val;
        if (ramp_en)
            smp_nxt = {smp_r[3] + 16'h3131, smp_r[2] + 16'h2222, smp_r[1] + 16'h0F0F, smp_r[0] + 16'h1234};
    end
    always_ff @(posedge core_clk)
        smp_r <= smp_nxt;
    assign internal_sample_u = smp_r[0];
    assign internal_sample_v = smp_r[1];
    assign external_sample_zero = smp_r[2];
    assign external_sample_one = smp_r[3];
endmodule // sample_source_model
`default_nettype wire

//--- bench/current_adc_select_scaler_tb.sv
// Register-level testbench of the current selector and scaler.
`timescale 1ns/1ps
`default_nettype none
module current_adc_select_scaler_tb
    import current_scaler_pkg::*;
;
    logic core_clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, ramp_en = 1'h0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, dat_o, junk;
    logic [15:0] su, sv, se0, se1, x0, x1, th;
    logic signed [15:0] pux, pv, pwy;
    logic f3, f2, f1;
    logic [3:0][15:0] set_val = '0;
    logic [15:0] raw_t [5] = '{16'h9000, 16'h0000, 16'hFFFF, 16'h7000, 16'h8001};
    logic [15:0] off_t [5] = '{16'h8000, 16'h8000, 16'h0000, 16'h8000, 16'h8000};
    logic [15:0] gn_t [5] = '{16'h0180, 16'h0200, 16'h0100, 16'hFF00, 16'hFF80};
    int errors = 0, check_count = 0, j;

    current_adc_select_scaler dut_u (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .internal_sample_u(su), .internal_sample_v(sv),
        .external_sample_zero(se0), .external_sample_one(se1), .phase_ux_current(pux),
        .phase_v_current(pv), .phase_wy_current(pwy), .three_phase_vector_mode(f3),
        .two_phase_stepper_mode(f2), .single_coil_dc_mode(f1));
    sample_source_model src_u (.core_clk(core_clk), .ramp_en(ramp_en), .set_val(set_val),
        .internal_sample_u(su), .internal_sample_v(sv), .external_sample_zero(se0),
        .external_sample_one(se1));

    // Free-running clock of 100 MHz.
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic final_report;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask

    // One classic cycle; holds the request until ack is sampled at a rising edge.
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        int n;
        @(posedge core_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack !== 1'h1 && n < 50);
        r = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (ack !== 1'h1)
        begin
            errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'h1, a, d, junk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] r;
        wb_xfer(1'h0, a, 32'h0, r);
        chk(r & m, exp);
    endtask

    function automatic logic [15:0] sat16(input int s);
        return (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : s[15:0];
    endfunction

    function automatic logic [15:0] scale(input logic [15:0] r, input logic [15:0] o, input logic [15:0] g);
        return sat16(((int'(r) - int'(o)) * int'($signed(g))) >>> 8);
    endfunction

    function automatic logic [15:0] pick(input int c, input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] cc, input logic [15:0] d);
        return (c == 0) ? a : (c == 1) ? b : (c == 2) ? cc : (c == 3) ? d : 16'h0;
    endfunction

    // Reset values, unmapped and read-only places, selectors, scaling, routing and modes.
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'h1;
        rd_chk(REG_SOURCE_SEL, RST_SOURCE_SEL, 32'hFFFF);
        rd_chk(REG_OFFSET_CH1, {16'h0, RST_OFFSET}, 32'hFFFF);
        rd_chk(REG_GAIN_CH0, {16'h0, RST_GAIN}, 32'hFFFF);
        rd_chk(REG_ROUTE_SEL, RST_ROUTE_SEL, 32'hFFFFFF);
        rd_chk(REG_MODE, {30'h0, RST_MODE}, 32'h3);
        wr(8'h40, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'h0, 32'hFFFFFFFF);
        ramp_en <= 1'h1;
        repeat (40) @(posedge core_clk);
        ramp_en <= 1'h0;
        set_val <= {16'hFFFF, 16'h0001, 16'hA5A5, 16'h5A5A};
        wr(REG_RAW_EXT, 32'h12345678);
        rd_chk(REG_RAW_INT, 32'hA5A55A5A, 32'hFFFFFFFF);
        rd_chk(REG_RAW_EXT, 32'hFFFF0001, 32'hFFFFFFFF);
        for (int c = 0; c < 5; c++)
        begin
            wr(REG_SOURCE_SEL, {16'h0, 8'(4 - c), 8'(c)});
            rd_chk(REG_RAW_ROUTED, {pick(4 - c, 16'h5A5A, 16'hA5A5, 16'h0001, 16'hFFFF),
                   pick(c, 16'h5A5A, 16'hA5A5, 16'h0001, 16'hFFFF)}, 32'hFFFFFFFF);
        end
        wr(REG_SOURCE_SEL, 32'h00000302);
        for (int i = 0; i < 5; i++)
        begin
            j = (i + 1) % 5;
            set_val <= {raw_t[j], raw_t[i], 16'h0, 16'h0};
            wr(REG_OFFSET_CH0, {16'h0, off_t[i]});
            wr(REG_OFFSET_CH1, {16'h0, off_t[j]});
            wr(REG_GAIN_CH0, {16'h0, gn_t[i]});
            wr(REG_GAIN_CH1, {16'h0, gn_t[j]});
            x0 = scale(raw_t[i], off_t[i], gn_t[i]);
            x1 = scale(raw_t[j], off_t[j], gn_t[j]);
            th = sat16(-(int'($signed(x0)) + int'($signed(x1))));
            rd_chk(REG_SCALED, {x1, x0}, 32'hFFFFFFFF);
            rd_chk(REG_THIRD, {16'h0, th}, 32'hFFFF);
            for (int r = 0; r < 4; r++)
            begin
                wr(REG_ROUTE_SEL, {8'h0, 8'((r + 2) % 4), 8'((r + 1) % 4), 8'(r)});
                repeat (6) @(posedge core_clk);
                chk({16'h0, pux}, {16'h0, pick(r, x0, x1, th, 16'h0)});
                chk({16'h0, pv}, {16'h0, pick((r + 1) % 4, x0, x1, th, 16'h0)});
                chk({16'h0, pwy}, {16'h0, pick((r + 2) % 4, x0, x1, th, 16'h0)});
            end
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(REG_MODE, 32'(m));
            repeat (6) @(posedge core_clk);
            rd_chk(REG_MODE, 32'(m), 32'h3);
            chk({29'h0, f3, f2, f1}, {29'h0, m == 2, m == 1, m == 0});
            rd_chk(REG_THIRD, (m == 2) ? {16'h0, th} : 32'h0, 32'hFFFF);
        end
        rst_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        rd_chk(REG_MODE, {30'h0, RST_MODE}, 32'h3);
        ramp_en <= 1'h1;
        repeat (30) @(posedge core_clk);
        final_report();
    end
endmodule // current_adc_select_scaler_tb
`default_nettype wire
